/* File: include/vpta_pkg.sv */
`default_nettype none
package vpta_pkg;

  typedef logic signed [15:0] vpta_exp_t;
  typedef logic [15:0]        vpta_mant_t;
  typedef logic signed [63:0] vpta_wide_t;

  localparam int         FILT_TAPS     = 9;
  localparam int         RC_COUNT      = 4;
  localparam int         SEG_IN_LAST   = 159;
  localparam int         SEG_OUT_LAST  = 167;
  localparam logic [3:0] IDX_LAST      = 4'h8;
  localparam vpta_mant_t MANT_MIN      = 16'h4000;
  localparam vpta_mant_t MANT_UNITY    = 16'h7FFF;

  // Pseudo-floating constants
  localparam vpta_exp_t  E_PTH         = 16'sh0011;
  localparam vpta_mant_t M_PTH         = 16'h7EF4;
  localparam vpta_exp_t  E_MARGIN      = 16'sh001B;
  localparam vpta_mant_t M_MARGIN      = 16'h421F;
  localparam vpta_exp_t  E_PLEV        = 16'sh0013;
  localparam vpta_mant_t M_PLEV        = 16'h54A3;

  // Values after reset; threshold is 866656 in pseudo-floating form
  localparam vpta_exp_t  E_THVAD_INIT  = 16'sh0014;
  localparam vpta_mant_t M_THVAD_INIT  = 16'h69CB;
  localparam logic       PTCH_INIT     = 1'b1;

  // Tone test thresholds in Q15
  localparam vpta_wide_t FREQTH_Q15    = 64'sh0000_0000_0000_0C74;
  localparam vpta_wide_t PREDTH_Q15    = 64'sh0000_0000_0000_05B8;

  // Exponent first, mantissa only on a tie
  function automatic logic pfGreater(vpta_exp_t ea, vpta_mant_t ma,
                                     vpta_exp_t eb, vpta_mant_t mb);
    return (ea > eb) || ((ea == eb) && (ma > mb));
  endfunction

  // Returns {exponent, mantissa}; zero maps to all zero
  function automatic logic [31:0] normPf(logic [63:0] v);
    int p;
    logic [63:0] m;
    p = -1;
    m = '0;
    for (int i = 0; i < 64; i++)
      if (v[i]) p = i;
    if (p < 0) return 32'h0000_0000;
    m = (p >= 14) ? (v >> (p - 14)) : (v << (14 - p));
    return {16'(p + 1), m[15:0]};
  endfunction

  function automatic vpta_wide_t autoCorr(logic [8:0][15:0] c, int lag);
    vpta_wide_t acc;
    acc = '0;
    for (int k = 0; k + lag < FILT_TAPS; k++)
      acc = acc + 64'(signed'(c[k]) * signed'(c[k + lag]));
    return acc;
  endfunction

  // Normalised residual energy of the fourth-order analysis, Q15
  function automatic vpta_wide_t predError(logic [3:0][15:0] rc);
    vpta_wide_t err;
    vpta_wide_t k2;
    err = 64'sh7FFF;
    k2 = '0;
    for (int i = 0; i < RC_COUNT; i++)
    begin
      k2 = 64'(signed'(rc[i]) * signed'(rc[i])) >>> 15;
      err = (err * (64'sh7FFF - k2)) >>> 15;
    end
    return err;
  endfunction

endpackage
`default_nettype wire

/* File: logic/vpta_pf_arith.sv */
`timescale 1ns/1ps
`default_nettype none
module vpta_pf_arith
  import vpta_pkg::*;
(
  input  wire logic       [15:0] mulAExp,
  input  wire logic       [15:0] mulAMant,
  input  wire logic       [15:0] mulBExp,
  input  wire logic       [15:0] mulBMant,
  input  wire logic       [15:0] addAExp,
  input  wire logic       [15:0] addAMant,
  input  wire logic       [15:0] addBExp,
  input  wire logic       [15:0] addBMant,
  output logic            [15:0] prodExp,
  output logic            [15:0] prodMant,
  output logic            [15:0] sumExp,
  output logic            [15:0] sumMant
);

  wire logic [31:0] rawProd   = mulAMant * mulBMant;
  wire logic [16:0] prodShift = rawProd[31:15];
  wire logic        prodLow   = (prodShift[15:0] < MANT_MIN);
  wire logic        prodZero  = (mulAMant == 16'h0000) || (mulBMant == 16'h0000);
  wire logic [15:0] expSum    = 16'(signed'(mulAExp) + signed'(mulBExp));

  // Product of two normalised mantissas is at least a quarter: one shift restores it
  assign prodExp  = prodZero ? 16'h0000 : (prodLow ? 16'(expSum - 16'h0001) : expSum);
  assign prodMant = prodZero ? 16'h0000 : (prodLow ? {prodShift[14:0], 1'b0} : prodShift[15:0]);

  //////////////////////////////////////////////////////////////////////////////

  wire logic        aBig    = signed'(addAExp) >= signed'(addBExp);
  wire logic [15:0] bigExp  = aBig ? addAExp : addBExp;
  wire logic [15:0] bigMant = aBig ? addAMant : addBMant;
  wire logic [15:0] smlMant = aBig ? addBMant : addAMant;
  wire logic [15:0] expDiff = aBig ? 16'(addAExp - addBExp) : 16'(addBExp - addAExp);
  // Alignment beyond 15 places drops the smaller operand entirely
  wire logic [15:0] aligned = (expDiff > 16'h000F) ? 16'h0000 : (smlMant >> expDiff[3:0]);
  wire logic [16:0] rawSum  = {1'b0, bigMant} + {1'b0, aligned};

  assign sumExp  = rawSum[16] ? 16'(bigExp + 16'h0001) : bigExp;
  assign sumMant = rawSum[16] ? rawSum[16:1] : rawSum[15:0];

endmodule // vpta_pf_arith
`default_nettype wire

/* File: logic/vpta_core.sv */
// What this block does
// R1: Reset loads every state variable with its initial value before any frame.
// R2: Frame work starts only when all autocorrelations and four coefficients are present.
// R3: Frame work uses the periodicity flag from the preceding frame.
// R4: Periodicity update runs after the decision and once both lags are available.
// R5: Filtered energy, threshold and frame energy are 16-bit exponent/mantissa pairs.
// R6: Exponent is smallest power of two above value; mantissa at least 16384. The add only renormalises on bit 16, so sum mantissas can exceed 32767.
// R7: Compare exponents first, mantissas only when exponents are equal.
// R8: One pseudo-floating add and one multiply, from plain integer operations.
// R9: Hold constants 17/32500, 27/16927 and 19/21667 as exponent/mantissa pairs.
// R10: Energy of eighth-order block filter over 160 samples, outputs 0 to 167.
// R11: Second-order coefficients from first two reflection values by step-up, a0 one.
// R12: Real part minus a1 half; negative imaginary term means no tone.
// R13: Negative real part skips the low-frequency check, goes to error test.
// R14: Both positive: ratio below 0.0973 means pole under 385 Hz, no tone.
// R15: Tone when normalised prediction error is below 0.0447.
// R16: Encoder strobes each frame once; done rises before the next strobe.
`timescale 1ns/1ps
`default_nettype none
module vpta_core
  import vpta_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             frameValid,
  input  wire logic [8:0][15:0] acfVals,
  input  wire logic [8:0][15:0] predCoefs,
  input  wire logic      [15:0] acfScaleExp,
  input  wire logic      [15:0] acfScaleMant,
  input  wire logic      [15:0] inputFrameEnergyExp,
  input  wire logic      [15:0] inputFrameEnergyMant,
  input  wire logic [3:0][15:0] reflectionCoefs,
  input  wire logic             lagsValid,
  input  wire logic             periodicIn,
  output logic                  frameDone,
  output logic                  vadDecision,
  output logic                  toneFlag,
  output logic                  periodicFlag,
  output logic           [15:0] pvadExp,
  output logic           [15:0] pvadMant,
  output logic           [15:0] thvadExp,
  output logic           [15:0] thvadMant
);

  typedef enum logic [1:0] {ST_IDLE, ST_FILT, ST_NORM, ST_DECIDE} vpta_state_e;

  vpta_state_e state_reg;
  vpta_state_e state_next;
  logic  [3:0] idx_reg;
  vpta_wide_t  acc_reg;
  logic        ptchUsed_reg;
  logic        decided_reg;
  logic        pend_reg;
  logic        pendVal_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Block filter energy: pvad = r0*acf[0] + 2*sum r[i]*acf[i]

  vpta_wide_t rVal [FILT_TAPS];

  for (genvar gi = 0; gi < FILT_TAPS; gi++)
  begin : gen_autocorr
    assign rVal[gi] = autoCorr(predCoefs, gi);  // [R10]
  end

  wire vpta_wide_t acfSel  = 64'(signed'(acfVals[idx_reg]));
  wire vpta_wide_t product = rVal[idx_reg] * acfSel;
  wire vpta_wide_t term    = (idx_reg == 4'h0) ? product : (product <<< 1);  // [R10]
  // Rounding can drive the sum slightly negative; energy floors at zero
  wire logic [63:0] energyAbs = acc_reg[63] ? 64'h0 : acc_reg;
  wire logic [31:0] energyPf  = normPf(energyAbs);  // [R6]

  //////////////////////////////////////////////////////////////////////////////
  // Pole test and prediction error

  wire vpta_wide_t rc1   = 64'(signed'(reflectionCoefs[0]));
  wire vpta_wide_t rc2   = 64'(signed'(reflectionCoefs[1]));
  wire vpta_wide_t a1    = rc1 + ((rc1 * rc2) >>> 15);  // [R11]
  wire vpta_wide_t a2    = rc2;                         // [R11]
  wire vpta_wide_t a1Sq  = a1 * a1;
  wire vpta_wide_t im4   = (a2 <<< 17) - a1Sq;          // [R12]
  wire logic       imNeg = im4 < 0;                     // [R12]
  wire logic       reNeg = a1 > 0;                      // [R12] [R13]
  wire logic       freqLow = (im4 <<< 15) < (FREQTH_Q15 * a1Sq);  // [R14]
  wire logic       errLow  = predError(reflectionCoefs) < PREDTH_Q15;  // [R15]
  wire logic       toneNext = !imNeg && (reNeg || !freqLow) && errLow;  // [R12] [R13] [R14]

  //////////////////////////////////////////////////////////////////////////////
  // Pseudo-floating arithmetic

  logic [15:0] prodExp;
  logic [15:0] prodMant;
  logic [15:0] sumExp;
  logic [15:0] sumMant;

  vpta_pf_arith u_arith (
    .mulAExp  (energyPf[31:16]),
    .mulAMant (energyPf[15:0]),
    .mulBExp  (acfScaleExp),
    .mulBMant (acfScaleMant),
    .addAExp  (pvadExp),
    .addAMant (pvadMant),
    .addBExp  (E_MARGIN),
    .addBMant (M_MARGIN),
    .prodExp  (prodExp),
    .prodMant (prodMant),
    .sumExp   (sumExp),
    .sumMant  (sumMant)
  );  // [R8]

  wire logic lowEnergy = pfGreater(E_PTH, M_PTH, inputFrameEnergyExp,
                                   inputFrameEnergyMant);  // [R7] [R9]
  wire logic voiced    = pfGreater(pvadExp, pvadMant, thvadExp, thvadMant);  // [R7]
  wire logic ceilLower = pfGreater(thvadExp, thvadMant, sumExp, sumMant);    // [R7]
  wire logic adaptOk   = !ptchUsed_reg && !toneNext;  // [R3]

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing

  wire logic start   = (state_reg == ST_IDLE) && frameValid;  // [R2] [R16]
  wire logic lagHave = lagsValid || pend_reg;
  wire logic lagVal  = lagsValid ? periodicIn : pendVal_reg;
  // Lags may come early; they wait until this frame's decision is out
  wire logic ptchApply = lagHave && decided_reg && (state_reg == ST_IDLE);  // [R4]

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   state_next = frameValid ? ST_FILT : ST_IDLE;
      ST_FILT:   state_next = (idx_reg == IDX_LAST) ? ST_NORM : ST_FILT;
      ST_NORM:   state_next = ST_DECIDE;
      ST_DECIDE: state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;  // [R1]
      idx_reg   <= 4'h0;
      acc_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= (state_reg == ST_FILT) ? 4'(idx_reg + 4'h1) : 4'h0;
      acc_reg   <= start ? '0 : ((state_reg == ST_FILT) ? acc_reg + term : acc_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Periodicity flag handling

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      periodicFlag <= PTCH_INIT;  // [R1]
      ptchUsed_reg <= PTCH_INIT;
      decided_reg  <= 1'b0;
      pend_reg     <= 1'b0;
      pendVal_reg  <= 1'b0;
    end
    else
    begin
      if (ptchApply)
        periodicFlag <= lagVal;  // [R4]
      if (start)
        ptchUsed_reg <= ptchApply ? lagVal : periodicFlag;  // [R3]
      decided_reg <= (state_reg == ST_DECIDE) || (decided_reg && !ptchApply);
      pend_reg    <= lagHave && !ptchApply;
      if (lagsValid)
        pendVal_reg <= periodicIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame results

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pvadExp     <= 16'h0000;  // [R1]
      pvadMant    <= 16'h0000;
      thvadExp    <= E_THVAD_INIT;
      thvadMant   <= M_THVAD_INIT;
      vadDecision <= 1'b0;
      toneFlag    <= 1'b0;
      frameDone   <= 1'b0;
    end
    else
    begin
      frameDone <= (state_reg == ST_DECIDE);  // [R16]
      if (state_reg == ST_NORM)
      begin
        pvadExp  <= prodExp;   // [R5] [R8]
        pvadMant <= prodMant;  // [R5]
      end
      if (state_reg == ST_DECIDE)
      begin
        vadDecision <= voiced;    // [R7]
        toneFlag    <= toneNext;  // [R15]
        if (lowEnergy)
        begin
          thvadExp  <= E_PLEV;  // [R9]
          thvadMant <= M_PLEV;
        end
        else if (adaptOk && ceilLower)
        begin
          // Threshold above filtered energy plus margin is pulled down to it
          thvadExp  <= sumExp;   // [R8] [R9]
          thvadMant <= sumMant;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Reference compare kept apart from the design's function, plus filter run length
  logic       thBefore;
  logic [3:0] filtLen_reg;
  always_ff @(posedge ref_clk)
  begin
    thBefore    <= ($signed(pvadExp) > $signed(thvadExp))
                   || ((pvadExp == thvadExp) && (pvadMant > thvadMant));
    filtLen_reg <= (state_reg == ST_FILT) ? 4'(filtLen_reg + 4'h1) : 4'h0;
  end

  sequence seqFilter;
    (state_reg == ST_FILT) && (filtLen_reg == 4'h0) ##8
      (state_reg == ST_FILT) && (filtLen_reg == IDX_LAST) ##1 (state_reg == ST_NORM);
  endsequence

  sequence seqFinish;
    (state_reg == ST_DECIDE) ##1 frameDone;
  endsequence

  chk_reset_values: assert property (  // [R1]
    disable iff (1'b0) reset |=> (thvadExp == E_THVAD_INIT) && (thvadMant == M_THVAD_INIT)
      && periodicFlag && !frameDone && (state_reg == ST_IDLE))
    else $error("state not initialised by reset");

  chk_filter_span: assert property (start |=> seqFilter)  // [R10] [R2]
    else $error("filter pass is not nine taps long");

  chk_done_timing: assert property (start |-> ##11 seqFinish)  // [R16]
    else $error("frame done not on cycle twelve");

  chk_ptch_frozen: assert property (  // [R3]
    (state_reg != ST_IDLE) |=> $stable(ptchUsed_reg))
    else $error("periodicity flag changed during frame work");

  chk_ptch_order: assert property (  // [R4]
    !$stable(periodicFlag) |-> $past(decided_reg) && $past(lagHave))
    else $error("periodicity updated before decision or lags");

  chk_mant_norm: assert property (  // [R6]
    (pvadMant == 16'h0000) || (pvadMant >= MANT_MIN))
    else $error("filtered energy mantissa not normalised");

  chk_vad_compare: assert property (  // [R7]
    (state_reg == ST_DECIDE) |=> (vadDecision == thBefore) && frameDone)
    else $error("decision disagrees with exponent first compare");

  chk_plev_load: assert property (  // [R9]
    (state_reg == ST_DECIDE) && lowEnergy |=> (thvadExp == E_PLEV) && (thvadMant == M_PLEV))
    else $error("low energy did not load lower threshold");

  chk_real_axis: assert property (  // [R12]
    (state_reg == ST_DECIDE) && imNeg |=> !toneFlag)
    else $error("real-axis poles declared a tone");

  chk_low_pole: assert property (  // [R14]
    (state_reg == ST_DECIDE) && !imNeg && !reNeg && freqLow |=> !toneFlag)
    else $error("low-frequency pole declared a tone");

  chk_high_pole: assert property (  // [R13] [R15]
    (state_reg == ST_DECIDE) && !imNeg && reNeg |=> (toneFlag == $past(errLow)))
    else $error("high pole tone not set by error test");

  chk_filter_count: assert property (  // [R10]
    (state_reg == ST_FILT) |-> (filtLen_reg <= IDX_LAST))
    else $error("filter pass longer than nine taps");

  chk_done_pulse: assert property (frameDone |=> !frameDone)  // [R16]
    else $error("frame done held beyond one cycle");

  chk_thvad_hold: assert property (  // [R5]
    (state_reg != ST_DECIDE) |=> $stable(thvadExp) && $stable(thvadMant))
    else $error("threshold changed outside the decision step");

  chk_result_hold: assert property (  // [R16]
    (state_reg != ST_DECIDE) |=> $stable(vadDecision) && $stable(toneFlag))
    else $error("decision outputs changed outside the decision step");

endmodule // vpta_core
`default_nettype wire

/* File: testbench/vpta_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vpta_enc_model
  import vpta_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             startReq,
  input  wire logic [3:0][15:0] reqRc,
  input  wire logic [8:0][15:0] reqAcf,
  input  wire logic      [15:0] reqA0,
  input  wire logic      [31:0] reqEn,
  input  wire logic       [3:0] lagDelay,
  input  wire logic             lagValue,
  input  wire logic             dblStrobe,
  input  wire logic             frameDone,
  output logic                  frameValid,
  output logic [8:0][15:0]      acfVals,
  output logic [8:0][15:0]      predCoefs,
  output logic           [15:0] acfScaleExp,
  output logic           [15:0] acfScaleMant,
  output logic           [15:0] inputFrameEnergyExp,
  output logic           [15:0] inputFrameEnergyMant,
  output logic [3:0][15:0]      reflectionCoefs,
  output logic                  lagsValid,
  output logic                  periodicIn
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  initial
  begin
    {frameValid, lagsValid, periodicIn, busy_reg, cnt_reg} = '0;
    {acfVals, predCoefs, reflectionCoefs} = '0;
    {acfScaleExp, acfScaleMant, inputFrameEnergyExp, inputFrameEnergyMant} = '0;
  end
  always @(posedge ref_clk)
  begin
    frameValid <= 1'b0;
    lagsValid  <= 1'b0;
    // Undriven result line toggles so a stale level never passes
    periodicIn <= ~periodicIn;
    if (reset)
      busy_reg <= 1'b0;
    else if (startReq)
    begin
      acfVals <= reqAcf;
      predCoefs <= {128'h0, reqA0};
      {acfScaleExp, acfScaleMant} <= {16'h0001, 16'h4000};
      {inputFrameEnergyExp, inputFrameEnergyMant} <= reqEn;
      reflectionCoefs <= reqRc;
      frameValid <= 1'b1;
      busy_reg <= 1'b1;
      cnt_reg <= 4'h0;
    end
    else if (busy_reg)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      // Stray strobe only when the bench asks for it
      if (dblStrobe && cnt_reg == 4'h4)
        frameValid <= 1'b1;
      if ((lagDelay != 4'h0 && cnt_reg == lagDelay) || (lagDelay == 4'h0 && frameDone))
      begin
        lagsValid <= 1'b1;
        periodicIn <= lagValue;
      end
      if (frameDone)
      begin
        busy_reg <= 1'b0;
        // Hold time over: values no longer valid
        acfVals <= ~acfVals;
        reflectionCoefs <= ~reflectionCoefs;
        predCoefs <= ~predCoefs;
      end
    end
  end
endmodule // vpta_enc_model
`default_nettype wire

/* File: testbench/vad_pole_tone_arith_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module vad_pole_tone_arith_bench
  import vpta_pkg::*;
;
  typedef struct packed {logic vad; logic tone; logic [31:0] thv; logic loud;} vpta_note_s;
  localparam int DONE_LAT = 12;
  logic             ref_clk, reset, startReq, lagValue, dblStrobe;
  logic [3:0][15:0] reqRc, reflectionCoefs;
  logic [8:0][15:0] reqAcf, acfVals, predCoefs;
  logic      [15:0] reqA0, acfScaleExp, acfScaleMant, pvadExp, pvadMant, thvadExp, thvadMant;
  logic      [15:0] inputFrameEnergyExp, inputFrameEnergyMant;
  logic      [31:0] reqEn, thv;
  logic       [3:0] lagDelay;
  logic             frameValid, lagsValid, periodicIn, frameDone, vadDecision, toneFlag;
  logic             periodicFlag, monBusy;
  int               miscompares, nChecks, seed, cyc, tStart;
  vpta_note_s       nt;
  vpta_note_s       notes[$];
  logic      [63:0] rcTab[5] = '{64'h7D00_7D00_C000_4000, 64'h7D00_7D00_2000_6400,
    64'h7D00_7D00_2000_9C00, 64'h7D00_7D00_2000_A000, 64'h0000_0000_2000_A000};
  logic      [31:0] enTab[5] = '{32'h0011_7EF4, 32'h0012_4000, 32'h0011_7EF5,
    32'h0011_7EF3, 32'h0010_7FFF};

  vpta_core i_dut (.ref_clk(ref_clk), .reset(reset), .frameValid(frameValid),
    .acfVals(acfVals), .predCoefs(predCoefs), .acfScaleExp(acfScaleExp),
    .acfScaleMant(acfScaleMant), .inputFrameEnergyExp(inputFrameEnergyExp),
    .inputFrameEnergyMant(inputFrameEnergyMant), .reflectionCoefs(reflectionCoefs),
    .lagsValid(lagsValid), .periodicIn(periodicIn), .frameDone(frameDone),
    .vadDecision(vadDecision), .toneFlag(toneFlag), .periodicFlag(periodicFlag),
    .pvadExp(pvadExp), .pvadMant(pvadMant), .thvadExp(thvadExp), .thvadMant(thvadMant));
  vpta_enc_model i_enc (.ref_clk(ref_clk), .reset(reset), .startReq(startReq),
    .reqRc(reqRc), .reqAcf(reqAcf), .reqA0(reqA0), .reqEn(reqEn), .lagDelay(lagDelay),
    .lagValue(lagValue), .dblStrobe(dblStrobe), .frameDone(frameDone),
    .frameValid(frameValid), .acfVals(acfVals), .predCoefs(predCoefs),
    .acfScaleExp(acfScaleExp), .acfScaleMant(acfScaleMant),
    .inputFrameEnergyExp(inputFrameEnergyExp), .inputFrameEnergyMant(inputFrameEnergyMant),
    .reflectionCoefs(reflectionCoefs), .lagsValid(lagsValid), .periodicIn(periodicIn));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    nChecks++;
    if (got !== ex)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  function automatic logic below(input logic [31:0] a, input logic [31:0] b);
    return ($signed(a[31:16]) < $signed(b[31:16])) || (a[31:16] == b[31:16] && a[15:0] < b[15:0]);
  endfunction

  function automatic logic toneExp(input logic [3:0][15:0] rc);
    longint a1, a2, im, err, k;
    a2 = longint'($signed(rc[1]));
    a1 = longint'($signed(rc[0]));
    a1 = a1 + ((a1 * a2) >>> 15);
    im = 4 * a2 * 32768 - a1 * a1;
    if (im < 0)
      return 1'b0;
    // Positive a1 means negative real part: low-frequency check skipped
    if (a1 <= 0 && im * 32768 < 3188 * a1 * a1)
      return 1'b0;
    err = 32767;
    for (int i = 0; i < 4; i++)
    begin
      k = (longint'($signed(rc[i])) * longint'($signed(rc[i]))) >>> 15;
      err = (err * (32767 - k)) >>> 15;
    end
    return err < 1464;
  endfunction

  task automatic complete_run;
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic doReset;
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    thv = {E_THVAD_INIT, M_THVAD_INIT};
    chk("reset out", 32'h1, {frameDone, vadDecision, toneFlag, periodicFlag});
    chk("reset pvad", 32'h0, {pvadExp, pvadMant});
    chk("reset thvad", thv, {thvadExp, thvadMant});
  endtask

  task automatic frame(input logic [63:0] rc, input logic loud, input logic [31:0] en,
                       input logic [3:0] ld, input logic lv, input logic dbl);
    vpta_note_s n;
    int i;
    if (below(en, {E_PTH, M_PTH}))
      thv = {E_PLEV, M_PLEV};
    n = '{loud, toneExp(rc), thv, loud};
    notes.push_back(n);
    @(posedge ref_clk);
    reqRc <= rc;
    reqA0 <= loud ? 16'h0100 : 16'h0000;
    reqEn <= en;
    {lagDelay, lagValue, dblStrobe, startReq} <= {ld, lv, dbl, 1'b1};
    reqAcf[0] <= 16'h4000;
    for (i = 1; i < 9; i++)
      reqAcf[i] <= 16'($random(seed));
    @(posedge ref_clk);
    startReq <= 1'b0;
    i = 0;
    while (frameDone !== 1'b1 && i < 40)
    begin
      @(posedge ref_clk);
      i++;
    end
    if (i == 40)
      chk("frame done seen", 32'h1, 32'h0);
    repeat (4) @(posedge ref_clk);
    #1 chk("periodic flag", 32'(lv), 32'(periodicFlag));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Result monitor: oldest note against each frame result
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (reset)
      monBusy <= 1'b0;
    else
    begin
      if (frameValid === 1'b1 && !monBusy)
      begin
        tStart <= cyc;
        monBusy <= 1'b1;
      end
      if (frameDone === 1'b1)
      begin
        monBusy <= 1'b0;
        chk("done latency", 32'(DONE_LAT), 32'(cyc - tStart));
        if (notes.size() == 0)
          chk("note queue", 32'h1, 32'h0);
        else
        begin
          nt = notes.pop_front();
          chk("vad", 32'(nt.vad), 32'(vadDecision));
          chk("tone", 32'(nt.tone), 32'(toneFlag));
          chk("thvad", nt.thv, {thvadExp, thvadMant});
          chk("pvad", nt.loud ? 32'h001F_4000 : 32'h0, {pvadExp, pvadMant});
        end
      end
    end
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    {reset, startReq, lagValue, dblStrobe, monBusy, cyc, tStart} = '0;
    {reqRc, reqAcf, reqA0, reqEn, lagDelay, nChecks, miscompares} = '0;
    seed = 34176;
    doReset();
    for (int i = 0; i < 5; i++)
    begin
      // Second reset mid-run restores the threshold
      if (i == 4)
      begin
        @(posedge ref_clk);
        doReset();
      end
      frame(rcTab[i], i[0], enTab[i], 4'(3 * (i % 3)), i[1], i == 2);
    end
    for (int j = 0; j < 20; j++)
      frame({16'($random(seed)), 16'($random(seed)), 16'(($random(seed) % 8) * 4096),
             16'(($random(seed) % 8) * 4096)}, 1'($random(seed)),
            {16'(16 + $unsigned($random(seed)) % 3), 2'b01, 14'($random(seed))},
            4'(3 * ($unsigned($random(seed)) % 3)), 1'($random(seed)), 1'b0);
    complete_run();
  end
endmodule // vad_pole_tone_arith_bench
`default_nettype wire
